// [src/cpa_pkg.sv]
package cpa_pkg;

  // program counter and pointer stepping
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [14:0] PAGE_MASK = 15'h7000;
  localparam logic [14:0] HIGH_MASK = 15'h7f00;
  localparam logic [14:0] REL_BIAS = 15'h001f;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [3:0] LDB_HI_NIB = 4'h0;

  // fixed program-memory locations
  localparam logic [14:0] TRAP_ADDR = 15'h00ff;
  localparam logic [14:0] VEC_BASE = 15'h01e0;

  // instruction lengths in bytes
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;

  // opcode groups: 00ffffff relative jump, 10fffmmm accumulator op with mode
  localparam logic [1:0] GRP_REL = 2'h0;
  localparam logic [1:0] GRP_ALU = 2'h2;
  localparam logic [3:0] HI_LDB = 4'h4;
  localparam logic [3:0] HI_ABS_JUMP = 4'h5;
  localparam logic [3:0] HI_CALL = 4'h7;
  localparam logic [3:0] HI_XC = 4'hc;
  localparam logic [4:0] HI_XCH = 5'h18;
  localparam logic [4:0] HI_CMP = 5'h19;

  localparam logic [7:0] OP_LONG_JUMP = 8'h60;
  localparam logic [7:0] OP_CALLL = 8'h61;
  localparam logic [7:0] OP_RETURN = 8'h62;
  localparam logic [7:0] OP_RETURN_SKIP = 8'h63;
  localparam logic [7:0] OP_INT_RETURN = 8'h64;
  localparam logic [7:0] OP_TRAP = 8'h65;
  localparam logic [7:0] OP_VECTOR_SEL = 8'h66;
  localparam logic [7:0] OP_TRD = 8'h67;
  localparam logic [7:0] OP_TJMP = 8'h68;
  localparam logic [7:0] OP_NOP = 8'h69;
  localparam logic [7:0] OP_INC = 8'hd0;
  localparam logic [7:0] OP_DEC = 8'hd1;
  localparam logic [7:0] OP_DEC_ADJ = 8'hd2;
  localparam logic [7:0] OP_CLR = 8'hd3;
  localparam logic [7:0] OP_SETC = 8'hd4;
  localparam logic [7:0] OP_CLRC = 8'hd5;
  localparam logic [7:0] OP_ROT_RIGHT = 8'hd6;
  localparam logic [7:0] OP_ROT_LEFT = 8'hd7;
  localparam logic [7:0] OP_IFC = 8'hd8;
  localparam logic [7:0] OP_IFNC = 8'hd9;
  localparam logic [7:0] OP_SWAP = 8'hda;
  localparam logic [7:0] OP_PUSH = 8'hdb;
  localparam logic [7:0] OP_POP = 8'hdc;

  // operand modes, low three opcode bits
  localparam logic [2:0] MD_IMM = 3'h0;
  localparam logic [2:0] MD_DIR = 3'h1;
  localparam logic [2:0] MD_B = 3'h2;
  localparam logic [2:0] MD_X = 3'h3;
  localparam logic [2:0] MD_BINC = 3'h4;
  localparam logic [2:0] MD_BDEC = 3'h5;
  localparam logic [2:0] MD_XINC = 3'h6;
  localparam logic [2:0] MD_XDEC = 3'h7;

  // accumulator functions, opcode bits 5:3
  localparam logic [2:0] F_ADD = 3'h0;
  localparam logic [2:0] F_ADC = 3'h1;
  localparam logic [2:0] F_SUB_CARRY = 3'h2;
  localparam logic [2:0] F_SUB = 3'h3;
  localparam logic [2:0] F_AND = 3'h4;
  localparam logic [2:0] F_OR = 3'h5;
  localparam logic [2:0] F_XOR = 3'h6;
  localparam logic [2:0] F_LD = 3'h7;

  // decimal correction
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0] BCD_LO_ADJ = 8'h06;
  localparam logic [7:0] BCD_HI_ADJ = 8'h60;

  typedef enum logic [3:0] {
    ST_OPC = 4'h0,
    ST_B2 = 4'h1,
    ST_B3 = 4'h2,
    ST_MEM = 4'h3,
    ST_TBL = 4'h4,
    ST_POPH = 4'h5,
    ST_POPL = 4'h6,
    ST_VECH = 4'h7,
    ST_VECL = 4'h8,
    ST_PUSHH = 4'h9
  } cpa_state_t;

  typedef struct packed {
    cpa_state_t st;
    logic [14:0] pc;
    logic [14:0] addr;
    logic [14:0] tgt;
    logic [7:0] op;
    logic [7:0] ea;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] sp;
    logic carry;
    logic hc;
    logic gie;
    logic skip;
  } cpa_regs_t;

endpackage

// [src/cpa_dmem.sv]
`timescale 1ns/1ps
`default_nettype none

module cpa_dmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // read data is registered, so a read issued in one state is usable in the next
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

// [src/cpa_flow_core.sv]
`timescale 1ns/1ps
`default_nettype none

module cpa_flow_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // program memory, asynchronous read of pmem_addr
  output logic [14:0] pmem_addr,
  input wire logic [7:0] pmem_data,
  // interrupt source select for the vector fetch
  input wire logic [3:0] int_vec_sel,
  // visible core state
  output logic [7:0] acc_out,
  output logic [7:0] b_ptr,
  output logic [7:0] x_ptr,
  output logic [7:0] sp_out,
  output logic carry_out,
  output logic gie_out
);

  cpa_pkg::cpa_regs_t q;
  cpa_pkg::cpa_regs_t d;
  logic dm_we;
  logic [7:0] dm_addr;
  logic [7:0] dm_wd;
  logic [7:0] dm_rdata;
  logic [7:0] opnd;
  logic opnd_go;
  logic [7:0] dc_lo;
  logic [7:0] dc_hi;
  logic [9:0] alu_r;

  function automatic logic is_mem(input logic [7:0] o);
    return (o[7:6] == cpa_pkg::GRP_ALU) || (o[7:4] == cpa_pkg::HI_XC);
  endfunction

  function automatic logic [1:0] op_len(input logic [7:0] o);
    if (o == cpa_pkg::OP_LONG_JUMP || o == cpa_pkg::OP_CALLL) begin
      return cpa_pkg::LEN3;
    end
    if (o[7:4] == cpa_pkg::HI_ABS_JUMP || o[7:4] == cpa_pkg::HI_CALL) begin
      return cpa_pkg::LEN2;
    end
    if (is_mem(o) && (o[2:0] == cpa_pkg::MD_IMM || o[2:0] == cpa_pkg::MD_DIR)) begin
      return cpa_pkg::LEN2;
    end
    return cpa_pkg::LEN1;
  endfunction

  // returns {carry, half carry, result}; plain add and subtract leave flags alone
  function automatic logic [9:0] alu(input logic [2:0] f, input logic [7:0] a,
                                     input logic [7:0] m, input logic c, input logic h);
    logic [7:0] mm;
    logic cin;
    logic [8:0] sum;
    logic [4:0] half;
    mm = (f == cpa_pkg::F_SUB_CARRY || f == cpa_pkg::F_SUB) ? ~m : m;
    cin = (f == cpa_pkg::F_ADD) ? 1'b0 : (f == cpa_pkg::F_SUB) ? 1'b1 : c;
    sum = {1'b0, a} + {1'b0, mm} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, mm[3:0]} + {4'h0, cin};
    unique case (f)
      cpa_pkg::F_ADD, cpa_pkg::F_SUB: alu = {c, h, sum[7:0]};
      cpa_pkg::F_ADC, cpa_pkg::F_SUB_CARRY: alu = {sum[8], half[4], sum[7:0]};
      cpa_pkg::F_AND: alu = {c, h, a & m};
      cpa_pkg::F_OR: alu = {c, h, a | m};
      cpa_pkg::F_XOR: alu = {c, h, a ^ m};
      cpa_pkg::F_LD: alu = {c, h, m};
    endcase
  endfunction

  cpa_dmem #(
    .AW(8),
    .DW(8)
  ) u_dmem (
    .clk(ref_clk),
    .we(dm_we),
    .addr(dm_addr),
    .wdata(dm_wd),
    .rdata(dm_rdata)
  );

  always_comb begin
    d = q;
    dm_we = 1'b0;
    dm_addr = q.ea;
    dm_wd = q.acc;
    opnd = pmem_data;
    opnd_go = 1'b0;
    dc_lo = '0;
    dc_hi = '0;
    alu_r = '0;
    unique case (q.st)
      cpa_pkg::ST_OPC: begin
        d.op = pmem_data;
        d.pc = q.pc + cpa_pkg::PC_STEP;
        if (q.skip) begin
          // the skipped opcode is only measured, never executed
          d.skip = 1'b0;
          d.pc = q.pc + {13'h0000, op_len(pmem_data)};
        end else if (op_len(pmem_data) != cpa_pkg::LEN1) begin
          d.st = cpa_pkg::ST_B2;
        end else if (is_mem(pmem_data)) begin
          // indirect modes; mode bit 2 selects the post-modify forms
          d.ea = (pmem_data[2] ? pmem_data[1] : pmem_data[0]) ? q.x : q.b;
          dm_addr = d.ea;
          d.st = cpa_pkg::ST_MEM;
        end else if (pmem_data[7:6] == cpa_pkg::GRP_REL) begin
          // a field giving +1 would land on the next opcode anyway
          d.pc = q.pc + {9'h000, pmem_data[5:0]} - cpa_pkg::REL_BIAS;
        end else if (pmem_data[7:4] == cpa_pkg::HI_LDB) begin
          d.b = {cpa_pkg::LDB_HI_NIB, pmem_data[3:0]};
        end else begin
          unique case (pmem_data)
            cpa_pkg::OP_RETURN, cpa_pkg::OP_RETURN_SKIP, cpa_pkg::OP_INT_RETURN: begin
              d.sp = q.sp + cpa_pkg::PTR_STEP;
              dm_addr = d.sp;
              d.st = cpa_pkg::ST_POPH;
            end
            cpa_pkg::OP_POP: begin
              d.sp = q.sp + cpa_pkg::PTR_STEP;
              dm_addr = d.sp;
              d.st = cpa_pkg::ST_MEM;
            end
            cpa_pkg::OP_PUSH: begin
              dm_we = 1'b1;
              dm_addr = q.sp;
              d.sp = q.sp - cpa_pkg::PTR_STEP;
            end
            cpa_pkg::OP_TRAP: begin
              dm_we = 1'b1;
              dm_addr = q.sp;
              dm_wd = d.pc[7:0];
              d.sp = q.sp - cpa_pkg::PTR_STEP;
              d.tgt = cpa_pkg::TRAP_ADDR;
              d.gie = 1'b0;
              d.st = cpa_pkg::ST_PUSHH;
            end
            cpa_pkg::OP_VECTOR_SEL: begin
              d.addr = cpa_pkg::VEC_BASE + {10'h000, int_vec_sel, 1'b0};
              d.st = cpa_pkg::ST_VECH;
            end
            cpa_pkg::OP_TRD, cpa_pkg::OP_TJMP: begin
              d.addr = {d.pc[14:8], q.acc};
              d.st = cpa_pkg::ST_TBL;
            end
            cpa_pkg::OP_INC: d.acc = q.acc + cpa_pkg::PTR_STEP;
            cpa_pkg::OP_DEC: d.acc = q.acc - cpa_pkg::PTR_STEP;
            cpa_pkg::OP_DEC_ADJ: begin
              dc_lo = (q.hc || q.acc[3:0] > cpa_pkg::BCD_DIGIT_MAX) ? cpa_pkg::BCD_LO_ADJ : '0;
              dc_hi = (q.carry || q.acc > cpa_pkg::BCD_BYTE_MAX) ? cpa_pkg::BCD_HI_ADJ : '0;
              d.acc = q.acc + dc_lo + dc_hi;
              d.carry = q.carry || (dc_hi != '0);
            end
            cpa_pkg::OP_CLR: d.acc = '0;
            cpa_pkg::OP_SETC: d.carry = 1'b1;
            cpa_pkg::OP_CLRC: d.carry = 1'b0;
            cpa_pkg::OP_ROT_RIGHT: {d.acc, d.carry} = {q.carry, q.acc};
            cpa_pkg::OP_ROT_LEFT: {d.carry, d.acc} = {q.acc, q.carry};
            cpa_pkg::OP_SWAP: d.acc = {q.acc[3:0], q.acc[7:4]};
            cpa_pkg::OP_IFC: d.skip = !q.carry;
            cpa_pkg::OP_IFNC: d.skip = q.carry;
            default: ; // no-operation and unused codes only step the counter
          endcase
        end
      end
      cpa_pkg::ST_B2: begin
        d.pc = q.pc + cpa_pkg::PC_STEP;
        d.st = cpa_pkg::ST_OPC;
        if (q.op[7:4] == cpa_pkg::HI_ABS_JUMP) begin
          d.pc = {q.pc[14:12], q.op[3:0], pmem_data};
        end else if (q.op[7:4] == cpa_pkg::HI_CALL) begin
          dm_we = 1'b1;
          dm_addr = q.sp;
          dm_wd = d.pc[7:0];
          d.sp = q.sp - cpa_pkg::PTR_STEP;
          d.tgt = {q.pc[14:12], q.op[3:0], pmem_data};
          d.st = cpa_pkg::ST_PUSHH;
        end else if (q.op == cpa_pkg::OP_LONG_JUMP || q.op == cpa_pkg::OP_CALLL) begin
          d.tgt[14:8] = pmem_data[6:0];
          d.st = cpa_pkg::ST_B3;
        end else if (q.op[2:0] == cpa_pkg::MD_DIR) begin
          d.ea = pmem_data;
          dm_addr = pmem_data;
          d.st = cpa_pkg::ST_MEM;
        end else begin
          opnd_go = 1'b1;
        end
      end
      cpa_pkg::ST_B3: begin
        d.pc = q.pc + cpa_pkg::PC_STEP;
        d.st = cpa_pkg::ST_OPC;
        if (q.op == cpa_pkg::OP_LONG_JUMP) begin
          d.pc = {q.tgt[14:8], pmem_data};
        end else begin
          dm_we = 1'b1;
          dm_addr = q.sp;
          dm_wd = d.pc[7:0];
          d.sp = q.sp - cpa_pkg::PTR_STEP;
          d.tgt = {q.tgt[14:8], pmem_data};
          d.st = cpa_pkg::ST_PUSHH;
        end
      end
      cpa_pkg::ST_PUSHH: begin
        // high byte goes below the low byte so a return pops it first
        dm_we = 1'b1;
        dm_addr = q.sp;
        dm_wd = {1'b0, q.pc[14:8]};
        d.sp = q.sp - cpa_pkg::PTR_STEP;
        d.pc = q.tgt;
        d.st = cpa_pkg::ST_OPC;
      end
      cpa_pkg::ST_MEM: begin
        opnd = dm_rdata;
        opnd_go = 1'b1;
        d.st = cpa_pkg::ST_OPC;
        // pointer moves only once the access has finished
        if (is_mem(q.op) && q.op[2]) begin
          if (q.op[1]) begin
            d.x = q.op[0] ? q.x - cpa_pkg::PTR_STEP : q.x + cpa_pkg::PTR_STEP;
          end else begin
            d.b = q.op[0] ? q.b - cpa_pkg::PTR_STEP : q.b + cpa_pkg::PTR_STEP;
          end
        end
      end
      cpa_pkg::ST_TBL: begin
        d.st = cpa_pkg::ST_OPC;
        if (q.op == cpa_pkg::OP_TRD) begin
          d.acc = pmem_data;
        end else begin
          d.pc = {q.pc[14:8], pmem_data};
        end
      end
      cpa_pkg::ST_POPH: begin
        d.tgt[14:8] = dm_rdata[6:0];
        d.sp = q.sp + cpa_pkg::PTR_STEP;
        dm_addr = d.sp;
        d.st = cpa_pkg::ST_POPL;
      end
      cpa_pkg::ST_POPL: begin
        d.pc = {q.tgt[14:8], dm_rdata};
        d.skip = (q.op == cpa_pkg::OP_RETURN_SKIP);
        d.gie = q.gie || (q.op == cpa_pkg::OP_INT_RETURN);
        d.st = cpa_pkg::ST_OPC;
      end
      cpa_pkg::ST_VECH: begin
        d.tgt[14:8] = pmem_data[6:0];
        d.addr = q.addr + cpa_pkg::PC_STEP;
        d.st = cpa_pkg::ST_VECL;
      end
      cpa_pkg::ST_VECL: begin
        d.pc = {q.tgt[14:8], pmem_data};
        d.st = cpa_pkg::ST_OPC;
      end
      default: d.st = cpa_pkg::ST_OPC;
    endcase
    if (opnd_go) begin
      if (q.op[7:6] == cpa_pkg::GRP_ALU) begin
        alu_r = alu(q.op[5:3], q.acc, opnd, q.carry, q.hc);
        {d.carry, d.hc, d.acc} = alu_r;
      end else if (q.op[7:3] == cpa_pkg::HI_XCH) begin
        // exchange needs a memory location, so its immediate form does nothing
        if (q.op[2:0] != cpa_pkg::MD_IMM) begin
          dm_we = 1'b1;
          dm_addr = q.ea;
          dm_wd = q.acc;
          d.acc = opnd;
        end
      end else if (q.op[7:3] == cpa_pkg::HI_CMP) begin
        d.skip = (q.acc != opnd);
      end else if (q.op == cpa_pkg::OP_POP) begin
        d.acc = opnd;
      end
    end
    // the fetch address follows the counter whenever a code byte is next
    if (d.st == cpa_pkg::ST_OPC || d.st == cpa_pkg::ST_B2 || d.st == cpa_pkg::ST_B3) begin
      d.addr = d.pc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      q <= '{st: cpa_pkg::ST_OPC, pc: cpa_pkg::PC_RESET, addr: cpa_pkg::PC_RESET,
             tgt: cpa_pkg::PC_RESET, op: '0, ea: '0, acc: '0, b: '0, x: '0,
             sp: cpa_pkg::SP_RESET, carry: 1'b0, hc: 1'b0, gie: 1'b0, skip: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pmem_addr = q.addr;
  assign acc_out = q.acc;
  assign b_ptr = q.b;
  assign x_ptr = q.x;
  assign sp_out = q.sp;
  assign carry_out = q.carry;
  assign gie_out = q.gie;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  ptr_post_inc_a:
  assert property ((q.st == cpa_pkg::ST_MEM && q.op[7:6] == cpa_pkg::GRP_ALU
                    && q.op[2:0] == cpa_pkg::MD_BINC) |=> q.b == $past(q.b) + cpa_pkg::PTR_STEP)
    else $error("b pointer did not step up after access");

  imm_fetch_addr_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data[7:6] == cpa_pkg::GRP_ALU
                    && pmem_data[2:0] == cpa_pkg::MD_IMM)
                   |=> q.st == cpa_pkg::ST_B2 && pmem_addr == $past(q.pc) + cpa_pkg::PC_STEP)
    else $error("immediate byte not fetched after opcode");

  ldb_short_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data[7:4] == cpa_pkg::HI_LDB)
                   |=> q.b == {cpa_pkg::LDB_HI_NIB, q.op[3:0]})
    else $error("short b load wrong");

  table_read_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data == cpa_pkg::OP_TRD)
                   |=> (q.st == cpa_pkg::ST_TBL && pmem_addr[7:0] == q.acc)
                   ##1 (q.st == cpa_pkg::ST_OPC && pmem_addr == q.pc && q.acc == $past(pmem_data)))
    else $error("table read sequence wrong");

  rel_jump_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data[7:6] == cpa_pkg::GRP_REL)
                   |=> q.pc == $past(q.pc) + {9'h000, q.op[5:0]} - cpa_pkg::REL_BIAS)
    else $error("relative jump target wrong");

  abs_jump_a:
  assert property ((q.st == cpa_pkg::ST_B2 && q.op[7:4] == cpa_pkg::HI_ABS_JUMP)
                   |=> ((q.pc ^ $past(q.pc)) & cpa_pkg::PAGE_MASK) == '0
                       && q.pc[11:0] == {q.op[3:0], $past(pmem_data)})
    else $error("absolute jump target wrong");

  long_jump_a:
  assert property ((q.st == cpa_pkg::ST_B3 && q.op == cpa_pkg::OP_LONG_JUMP)
                   |=> q.st == cpa_pkg::ST_OPC && q.pc[7:0] == $past(pmem_data)
                       && pmem_addr == q.pc)
    else $error("long jump target wrong");

  table_jump_a:
  assert property ((q.st == cpa_pkg::ST_TBL && q.op == cpa_pkg::OP_TJMP)
                   |=> q.pc[7:0] == $past(pmem_data)
                       && ((q.pc ^ $past(q.pc)) & cpa_pkg::HIGH_MASK) == '0)
    else $error("table jump changed high byte");

  skip_no_effect_a:
  assert property ((q.st == cpa_pkg::ST_OPC && q.skip)
                   |=> q.st == cpa_pkg::ST_OPC && !q.skip && q.acc == $past(q.acc)
                       && q.b == $past(q.b) && q.x == $past(q.x) && q.sp == $past(q.sp))
    else $error("skipped instruction had an effect");

  carry_test_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data == cpa_pkg::OP_IFC)
                   |=> q.skip == !$past(q.carry))
    else $error("carry test skip wrong");

  return_pop_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data == cpa_pkg::OP_RETURN)
                   |=> q.st == cpa_pkg::ST_POPH ##1 q.st == cpa_pkg::ST_POPL
                   ##1 (q.st == cpa_pkg::ST_OPC
                        && q.sp == $past(q.sp, 3) + cpa_pkg::PTR_STEP + cpa_pkg::PTR_STEP))
    else $error("return did not pop two bytes");

  return_skip_a:
  assert property ((q.st == cpa_pkg::ST_POPL && q.op == cpa_pkg::OP_RETURN_SKIP) |=> q.skip)
    else $error("return then skip did not arm skip");

  seq_advance_a:
  assert property ((q.st == cpa_pkg::ST_OPC && !q.skip && pmem_data == cpa_pkg::OP_NOP)
                   |=> q.pc == $past(q.pc) + cpa_pkg::PC_STEP && pmem_addr == q.pc)
    else $error("counter did not advance");

endmodule

`default_nettype wire

// [bench/cpa_pmem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cpa_pmem_model (
  // fetch side
  input wire logic [14:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [0:32767];

  // asynchronous rom: the core samples the byte in the same cycle
  assign data = mem[addr];
endmodule

`default_nettype wire

// [bench/cpu_addressing_and_flow_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_addressing_and_flow_control_tb;
  logic ref_clk;
  logic resetn;
  logic [14:0] pmem_addr;
  logic [7:0] pmem_data;
  logic [3:0] int_vec_sel;
  logic [7:0] acc_out, b_ptr, x_ptr, sp_out;
  logic carry_out, gie_out;
  int miscompares = 0;
  int samples_checked = 0;

  cpa_flow_core DUT (
    .ref_clk(ref_clk), .resetn(resetn), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
    .int_vec_sel(int_vec_sel), .acc_out(acc_out), .b_ptr(b_ptr), .x_ptr(x_ptr),
    .sp_out(sp_out), .carry_out(carry_out), .gie_out(gie_out)
  );
  cpa_pmem_model u_pmem (.addr(pmem_addr), .data(pmem_data));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ld(input logic [14:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_pmem.mem[a + 15'(i)] = b[i];
  endtask

  // unloaded rom reads as nop so a stray fetch is harmless but visible
  task automatic start(input logic [3:0] sel);
    @(posedge ref_clk);
    resetn <= 1'b0;
    int_vec_sel <= sel;
    // rom is refilled off the edge while reset is already low
    @(negedge ref_clk);
    for (int i = 0; i < 32768; i++) u_pmem.mem[i] = cpa_pkg::OP_NOP;
  endtask

  // every program ends in a jump-to-self, so a settled pc marks completion
  task automatic run_to(input logic [14:0] last);
    int n;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    n = 0;
    while (pmem_addr !== last && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
    #1;
    check("pc", last, pmem_addr);
  endtask

  task automatic t_modes();
    start(4'h0);
    ld(15'h0000, '{8'hbd, 8'h4c, 8'hb8, 8'h5a, 8'hc4, 8'hb8, 8'h33, 8'hc5, 8'hbc,
                   8'hb0, 8'hff, 8'h22, 8'hb8, 8'h00, 8'hc3, 8'hbe, 8'h1f});
    run_to(15'h0010);
    check("x", 15'h0001, {7'h0, x_ptr});
    check("acc", 15'h00a5, {7'h0, acc_out});
    check("b", 15'h000d, {7'h0, b_ptr});
  endtask

  task automatic t_jumps();
    start(4'h0);
    ld(15'h0000, '{8'h5a, 8'h34});
    ld(15'h0a34, '{8'h60, 8'h92, 8'h34});
    // relative field 32 is never placed in a program
    ld(15'h1234, '{8'h3f});
    ld(15'h1254, '{8'h00});
    ld(15'h1235, '{8'h5f, 8'hff});
    ld(15'h1fff, '{8'h1f});
    run_to(15'h1fff);
  endtask

  task automatic t_calls();
    start(4'h0);
    ld(15'h0000, '{8'hb8, 8'h05, 8'h71, 8'h00, 8'h61, 8'h02, 8'h00, 8'hb8, 8'h77,
                   8'h67, 8'h68});
    ld(15'h0100, '{8'h62});
    ld(15'h0200, '{8'h63});
    ld(15'h0071, '{8'hdb, 8'hd3, 8'hdc, 8'hd8, 8'hb8, 8'h99, 8'hd4, 8'hd9, 8'hb8,
                   8'h88, 8'h1f});
    run_to(15'h007b);
    check("acc", 15'h0002, {7'h0, acc_out});
    check("sp", 15'h006f, {7'h0, sp_out});
    check("carry", 15'h0001, {14'h0, carry_out});
  endtask

  task automatic t_vector();
    start(4'h3);
    ld(15'h0000, '{8'h66});
    ld(15'h00ff, '{8'h64});
    ld(15'h01e6, '{8'h03, 8'h40});
    // ends with a nop, then a trap whose handler returns from interrupt
    ld(15'h0340, '{8'hd4, 8'hb8, 8'h58, 8'h88, 8'h27, 8'hd2, 8'hd6, 8'hda, 8'hd0,
                   8'h90, 8'h05, 8'h69, 8'h65, 8'h1f});
    run_to(15'h034d);
    check("gie", 15'h0001, {14'h0, gie_out});
    check("sp", 15'h006f, {7'h0, sp_out});
    check("acc", 15'h002f, {7'h0, acc_out});
    check("carry", 15'h0001, {14'h0, carry_out});
  endtask

  initial begin
    resetn = 1'b0;
    int_vec_sel = 4'h0;
    t_modes();
    t_jumps();
    t_calls();
    t_vector();
    finish_test();
  end

  // four scenarios of well under 400 cycles each
  initial begin
    #(50 * 5000);
    miscompares++;
    finish_test();
  end
endmodule

`default_nettype wire
